// ---- supply_seq_pkg.sv ----
// package: constants, states and carrier structs for the supply start-up sequencer
package supply_seq_pkg;

  // core clock rate and boot wait
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BOOT_TIME_US = 1200;
  localparam int unsigned BOOT_CYCLES = (BOOT_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BOOT_CNT_W = 17;

  // fixed analogue figures (mV and uA); the front model compares against the bulk under-voltage one
  localparam int unsigned SUPPLY_TURN_ON_THRESHOLD_MV = 20500;
  localparam int unsigned BULK_UNDERVOLTAGE_CURRENT_THRESHOLD_UA = 443;

  // reset values of pin controls
  localparam logic STARTUP_CELL_RESET = 1'b1;
  localparam logic UART_ENABLE_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_CHARGE  = 3'b000,
    ST_BOOT    = 3'b001,
    ST_WAIT_BI = 3'b010,
    ST_RUN     = 3'b011,
    ST_STOPPED = 3'b100
  } seq_state_t;

  // comparator decisions from the analogue front end
  typedef struct packed {
    logic supply_above_turn_on;
    logic supply_above_brownin;
    logic supply_above_off;
    logic bulk_brownin;
    logic bulk_current_above_bo;
  } comp_t;

  // gate requests from the pwm core and resulting pin drives
  typedef struct packed {
    logic main_gate_drive;
    logic zvs_gate_drive;
  } gate_t;

  // configuration pin control
  typedef struct packed {
    logic uart_enable;
    logic pull_down_enable;
  } cfg_pin_t;

endpackage

// ---- supply_startup_brownin_sequencer.sv ----
// start-up, brown-in and brown-out sequencing of the flyback controller core
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (RULE1) The configuration pin works as a one-wire UART until brown-in is reached.
// (RULE2) When normal operation starts the UART is turned off and the pin goes to weak pull-down.
// (RULE3) On a cold start the high-voltage start-up cell conducts to charge the supply capacitor.
// (RULE4) Supply rising above the turn-on threshold turns the start-up cell off and enables the core.
// (RULE5) After the core is enabled a boot wait of about 1.2 ms runs before any gate activity.
// (RULE6) Bulk and supply brown-in conditions are checked continuously during start-up.
// (RULE7) The first main gate pulse comes under soft-start only with both brown-ins and after the boot wait.
// (RULE8) With the core active, input brown-in monitoring measures the high-voltage pin current.
// (RULE9) Without input brown-in before supply falls below its brown-in level, measurement stays on to the off level.
// (RULE10) Bulk brown-out stops all gate switching.
// (RULE11) Bulk under-voltage is the high-voltage pin current falling below the fixed 0.443 mA threshold.
// (RULE12) Comparator decisions are synchronised first, and both gates stay low outside normal switching.
module supply_startup_brownin_sequencer (
  input wire logic clk,
  input wire logic reset_n,
  input wire supply_seq_pkg::comp_t comp_async,
  input wire supply_seq_pkg::gate_t gate_request,
  output supply_seq_pkg::gate_t gate_out,
  output logic startup_cell_on,
  output logic core_enable,
  output logic measure_enable,
  output logic soft_start,
  output supply_seq_pkg::cfg_pin_t cfg_pin
);
  import supply_seq_pkg::*;

  localparam int COMP_W = $bits(comp_t);

  logic [COMP_W-1:0] sync1;
  logic [COMP_W-1:0] sync2;
  logic [COMP_W-1:0] sync3;
  logic [COMP_W-1:0] stable;
  comp_t comp;
  seq_state_t state;
  seq_state_t next_state;
  logic [BOOT_CNT_W-1:0] boot_cnt;
  logic boot_done;
  logic bulk_brownin_seen;
  logic brownin_ok;
  logic bulk_brownout;
  logic supply_lost;

  // core power decode shared by the cell, core, measurement and pin controls
  function automatic logic core_alive(input seq_state_t s);
    return s != ST_CHARGE;
  endfunction

  // three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= comp_async; // see (RULE12)
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // per-bit agreement filter, avoids acting on a comparator mid-transition
  genvar gi;
  generate
    for (gi = 0; gi < COMP_W; gi++) begin : g_filt
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stable[gi] <= 1'b0;
        end else if (sync2[gi] == sync3[gi]) begin
          stable[gi] <= sync3[gi]; // see (RULE12)
        end
      end
    end
  endgenerate

  // filtered comparator decisions, the only copy the sequencing reads
  assign comp = comp_t'(stable);

  // brown-out: hv pin current below the 0.443 mA comparator level
  assign bulk_brownout = !comp.bulk_current_above_bo; // see (RULE11)
  assign brownin_ok = bulk_brownin_seen && comp.supply_above_brownin; // see (RULE6)
  assign boot_done = (boot_cnt == BOOT_CNT_W'(BOOT_CYCLES - 1));

  // supply at or under the off level; every live state falls back to charge-up
  assign supply_lost = !comp.supply_above_off;

  // boot wait counter, runs only in the boot state
  // holds at its last count; the state leaves boot on that same edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_cnt <= '0;
    end else if (state == ST_BOOT) begin
      if (!boot_done) begin
        boot_cnt <= boot_cnt + 1'b1; // see (RULE5)
      end
    end else begin
      boot_cnt <= '0;
    end
  end

  // bulk brown-in is latched once seen while the core is alive
  // the latch rides over bulk ripple dipping under the brown-in level later on
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bulk_brownin_seen <= 1'b0;
    end else if (state == ST_CHARGE) begin
      bulk_brownin_seen <= 1'b0;
    end else if (measure_enable && comp.bulk_brownin) begin
      bulk_brownin_seen <= 1'b1; // see (RULE8)
    end
  end

  // sequencing; a supply collapse below the off level always restarts charge-up
  always_comb begin
    next_state = state;
    case (state)
      ST_CHARGE: begin
        if (comp.supply_above_turn_on) begin
          next_state = ST_BOOT; // see (RULE4)
        end
      end
      ST_BOOT: begin
        if (supply_lost) begin
          next_state = ST_CHARGE;
        end else if (boot_done) begin
          next_state = ST_WAIT_BI; // see (RULE5)
        end
      end
      ST_WAIT_BI: begin
        if (supply_lost) begin
          next_state = ST_CHARGE; // see (RULE9)
        end else if (brownin_ok && !bulk_brownout) begin
          next_state = ST_RUN; // see (RULE7)
        end
      end
      ST_RUN: begin
        if (supply_lost) begin
          next_state = ST_CHARGE;
        end else if (bulk_brownout) begin
          next_state = ST_STOPPED; // see (RULE10)
        end
      end
      ST_STOPPED: begin
        // bulk recovery alone does not restart; only a supply collapse leaves
        if (supply_lost) begin
          next_state = ST_CHARGE;
        end
      end
      default: begin
        next_state = ST_CHARGE;
      end
    endcase
  end

  // state register; cell, core, measure, soft-start and pin outputs load from next_state on the same edge, gate_out from state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_CHARGE;
    end else begin
      state <= next_state;
    end
  end

  // start-up cell conducts only while charging the supply capacitor
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      startup_cell_on <= STARTUP_CELL_RESET; // see (RULE3)
      core_enable <= 1'b0;
      measure_enable <= 1'b0;
    end else begin
      // cell and core are complementary, so the cell never feeds a running core
      startup_cell_on <= !core_alive(next_state); // see (RULE4)
      core_enable <= core_alive(next_state);
      // measurement held on through boot and brown-in wait until supply off
      measure_enable <= core_alive(next_state); // see (RULE8) see (RULE9)
    end
  end

  // soft-start flag asserted on entry to run, one cycle, pwm core ramps from it
  // stopped never re-enters run directly, so each charge-up gives at most one pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_start <= 1'b0;
    end else begin
      soft_start <= (next_state == ST_RUN) && (state != ST_RUN); // see (RULE7)
    end
  end

  // gates forced low outside normal switching, registered for glitch-free pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_out <= '0;
    end else if (state == ST_RUN && !bulk_brownout) begin
      gate_out <= gate_request;
    end else begin
      gate_out <= '0; // see (RULE10) see (RULE12)
    end
  end

  // configuration pin: uart until brown-in, then weak pull-down until a supply collapse returns to charge-up
  // boot and brown-in wait keep the uart, so parameters can still be loaded
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_pin.uart_enable <= UART_ENABLE_RESET; // see (RULE1)
      cfg_pin.pull_down_enable <= 1'b0;
    end else if (!core_alive(next_state)) begin
      cfg_pin.uart_enable <= 1'b1; // see (RULE1)
      cfg_pin.pull_down_enable <= 1'b0;
    end else if (next_state == ST_RUN) begin
      cfg_pin.uart_enable <= 1'b0; // see (RULE2)
      cfg_pin.pull_down_enable <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ---- supply_front_model.sv ----
// model: analogue comparators ahead of the sequencer
`timescale 1ns/1ps
`default_nettype none
module supply_front_model #(
  parameter int TURN_ON_MV = 20500,
  parameter int BROWNIN_MV = 9100,
  parameter int OFF_MV = 7200,
  parameter int BULK_BI_UA = 500
) (
  input wire logic [15:0] supply_mv,
  input wire logic [15:0] hv_ua,
  output var supply_seq_pkg::comp_t comp
);
  import supply_seq_pkg::*;
  // ideal comparators, no hysteresis, so the bench sets levels well apart
  always_comb begin
    comp.supply_above_turn_on = supply_mv > TURN_ON_MV;
    comp.supply_above_brownin = supply_mv > BROWNIN_MV;
    comp.supply_above_off = supply_mv > OFF_MV;
    comp.bulk_brownin = hv_ua > BULK_BI_UA;
    comp.bulk_current_above_bo = hv_ua > BULK_UNDERVOLTAGE_CURRENT_THRESHOLD_UA;
  end
endmodule
`default_nettype wire

// ---- seq_monitor.sv ----
// checker: assertions on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module seq_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire supply_seq_pkg::comp_t comp_async,
  input wire supply_seq_pkg::gate_t gate_request,
  input wire supply_seq_pkg::gate_t gate_out,
  input wire logic startup_cell_on,
  input wire logic core_enable,
  input wire logic measure_enable,
  input wire logic soft_start,
  input wire supply_seq_pkg::cfg_pin_t cfg_pin
);
  import supply_seq_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [16:0] boot_cnt;
  // cycles with core on; saturates so it cannot wrap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_cnt <= '0;
    end else if (!core_enable) begin
      boot_cnt <= '0;
    end else if (boot_cnt != 17'h1FFFF) begin
      boot_cnt <= boot_cnt + 17'h1;
    end
  end
  // inputs need sync, filter, state and gate register to act
  sequence bo_held; !comp_async.bulk_current_above_bo [*8]; endsequence
  sequence off_held; !comp_async.supply_above_off [*7]; endsequence
  a_cell_core_excl: assert property (startup_cell_on |-> !core_enable) else $error("cell and core");
  a_core_start: assert property ($rose(core_enable) |-> !startup_cell_on && measure_enable) else $error("start");
  a_measure_core: assert property (core_enable |-> measure_enable) else $error("measure");
  a_pin_mode: assert property (cfg_pin.uart_enable != cfg_pin.pull_down_enable) else $error("pin");
  a_soft_pulse: assert property (soft_start |-> cfg_pin.pull_down_enable ##1 !soft_start) else $error("soft");
  a_boot_wait: assert property (soft_start |-> boot_cnt >= BOOT_CYCLES) else $error("boot");
  a_gate_follow: assert property (gate_out != 2'h0 |-> gate_out == $past(gate_request)) else $error("gate");
  a_brownout_stop: assert property (bo_held |-> gate_out == 2'h0) else $error("brownout");
  a_off_charge: assert property (off_held |-> startup_cell_on && !core_enable) else $error("off");
endmodule
bind supply_startup_brownin_sequencer seq_monitor mon (.clk(clk), .reset_n(reset_n), .comp_async(comp_async),
  .gate_request(gate_request), .gate_out(gate_out), .startup_cell_on(startup_cell_on), .core_enable(core_enable),
  .measure_enable(measure_enable), .soft_start(soft_start), .cfg_pin(cfg_pin));
`default_nettype wire

// ---- supply_startup_brownin_sequencer_test.sv ----
// testbench: start-up, brown-in and brown-out sequencing
`timescale 1ns/1ps
`default_nettype none
module supply_startup_brownin_sequencer_test;
  import supply_seq_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] supply_mv = 16'h0;
  logic [15:0] hv_ua = 16'h0;
  comp_t comp;
  gate_t gate_request = '0;
  gate_t gate_out;
  gate_t next_exp = '0;
  gate_t exp_q[$];
  logic startup_cell_on, core_enable, measure_enable, soft_start;
  cfg_pin_t cfg_pin;
  int n_fail = 0;
  int checked = 0;
  int seed = 32'h3B5A;
  int t;
  always #10 clk = ~clk;
  supply_front_model model (.supply_mv(supply_mv), .hv_ua(hv_ua), .comp(comp));
  supply_startup_brownin_sequencer dut (.clk(clk), .reset_n(reset_n), .comp_async(comp),
    .gate_request(gate_request), .gate_out(gate_out), .startup_cell_on(startup_cell_on),
    .core_enable(core_enable), .measure_enable(measure_enable), .soft_start(soft_start), .cfg_pin(cfg_pin));
  task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // each note is what the previous cycle's request must produce
  task automatic drive_gates(input int n, input logic pass);
    gate_t r;
    repeat (n) begin
      @(posedge clk);
      exp_q.push_back(next_exp);
      r = gate_t'(2'($random(seed)));
      gate_request <= r;
      next_exp = pass ? r : '0;
    end
    @(posedge clk);
    exp_q.push_back(next_exp);
    gate_request <= '0;
    next_exp = '0;
  endtask
  // gate pins are settled by the falling edge
  always @(negedge clk) begin
    while (exp_q.size() > 0) check("gate_out", {1'b0, exp_q.pop_front()}, {1'b0, gate_out});
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog: the tests take about 60200 cycles, 70000 cycles means a hang
  initial begin
    #1_400_000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check("cell cfg", 3'b110, {startup_cell_on, cfg_pin});
    drive_gates(8, 1'b0);
    @(posedge clk);
    hv_ua <= 16'h0258;
    supply_mv <= 16'h5208;
    t = 0;
    while (core_enable !== 1'b1 && t < 20) begin
      @(negedge clk);
      t++;
    end
    check("start", 3'b011, {startup_cell_on, core_enable, measure_enable});
    @(posedge clk);
    supply_mv <= 16'h2EE0;
    t = 0;
    while (soft_start !== 1'b1 && t < 61000) begin
      @(negedge clk);
      t++;
    end
    check("boot", 3'b001, {2'b00, t >= BOOT_CYCLES && t <= BOOT_CYCLES + 2});
    check("cfg run", 3'b001, {1'b0, cfg_pin});
    // 460 uA sits under the brown-in level but above the brown-out level
    @(posedge clk);
    hv_ua <= 16'h01CC;
    drive_gates(40, 1'b1);
    hv_ua <= 16'h0190;
    repeat (8) @(posedge clk);
    drive_gates(20, 1'b0);
    supply_mv <= 16'h1F40;
    repeat (10) @(negedge clk);
    check("measure", 3'b001, {1'b0, startup_cell_on, measure_enable});
    @(posedge clk);
    supply_mv <= 16'h1388;
    t = 0;
    while (startup_cell_on !== 1'b1 && t < 20) begin
      @(negedge clk);
      t++;
    end
    check("recharge", 3'b100, {startup_cell_on, core_enable, measure_enable});
    finish_test;
  end
endmodule
`default_nettype wire
